// ==== rtl/pfc_params.svh ====
/*
  Named constants of the PWM and over-temperature configuration bank.
  Assumes one clock of 250 MHz and a 12-bit temperature ADC result.
*/
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH

// Register byte addresses on the management register port
`define PFC_REG_CTRL 16'hfe14
`define PFC_REG_LIMIT 16'hfe15
`define PFC_REG_OFS_HI 16'hfe16
`define PFC_REG_OFS_LO 16'hfe17
`define PFC_REG_GAIN 16'hfe18
`define PFC_REG_OT_THR 16'hfe19

// Control register fields
`define PFC_CTRL_MODE_BIT 4
`define PFC_CTRL_RES_BIT 3
`define PFC_CTRL_DIS1_BIT 2
`define PFC_CTRL_DIS2_BIT 1
`define PFC_CTRL_GO_BIT 0
`define PFC_CTRL_RSVD_MASK 8'he0
`define PFC_CTRL_MODE_MASK 8'h10

// Trim fields
`define PFC_OFS_SIGN_BIT 1
`define PFC_OFS_MSB_BIT 0
`define PFC_GAIN_SIGN_BIT 7
`define PFC_GAIN_SHIFT 10

// Reset values
`define PFC_CTRL_RST 8'h00
`define PFC_LIMIT_RST 8'h00
`define PFC_TRIM_RST 8'h00
`define PFC_OT_THR_RST 8'h03

// Variant: 1 = dual-phase part, 0 = single-phase part
`define PFC_DUAL_PHASE 1'b1

// Widths
`define PFC_ADC_W 12
`define PFC_CMP_W 9
`define PFC_LIM_CYC_W 9
`define PFC_STEP_W 6
`define PFC_DEB_W 25

// Timing
`define PFC_CLK_NS 4
`define PFC_FINE_STEP_NS 5
`define PFC_COARSE_STEP_NS 40
`define PFC_MIN_ON_STEP_NS 80
`define PFC_MIN_OFF_FLOOR_NS 40
`define PFC_MIN_OFF_STEP_NS 80
`define PFC_DEBOUNCE_MS 100
`define PFC_DEBOUNCE_CYCLES (`PFC_DEBOUNCE_MS * 1000000 / `PFC_CLK_NS)

// Threshold scale: 800 mV over 256 codes, 3125 uV per code
`define PFC_THR_FULL_MV 800
`define PFC_THR_STEPS 256
`define PFC_THR_UV_PER_CODE (`PFC_THR_FULL_MV * 1000 / `PFC_THR_STEPS)

`endif

// ==== rtl/pfc_pkg.sv ====
/*
  Types of the PWM and over-temperature configuration bank.
  Assumes pfc_params.svh is on the include path.
*/
`include "pfc_params.svh"

package pfc_pkg;

  typedef enum logic [1:0] {
    PFC_DEB_IDLE = 2'b00,
    PFC_DEB_CNT = 2'b01,
    PFC_DEB_FLT = 2'b10
  } pfc_deb_st_t;

  typedef struct packed {
    pfc_deb_st_t st;
    logic [`PFC_DEB_W-1:0] cnt;
    logic fault;
  } pfc_deb_t;

  typedef struct packed {
    logic [7:0] ctrl_stg;
    logic [7:0] limit_stg;
    logic [7:0] ofs_hi;
    logic [7:0] ofs_lo;
    logic [7:0] gain;
    logic [7:0] ot_thr;
    logic act_bridgeless;
    logic act_fine;
    logic act_en1;
    logic act_en2;
    logic [`PFC_STEP_W-1:0] step_ns;
    logic [`PFC_LIM_CYC_W-1:0] min_on_cyc;
    logic [`PFC_LIM_CYC_W-1:0] min_off_cyc;
    logic commit;
    logic [7:0] rdata;
    logic rvalid;
    logic wr_reject;
    logic [`PFC_ADC_W-1:0] trimmed;
    logic trim_valid;
    logic below_thr;
  } pfc_cfg_st_t;

endpackage

// ==== rtl/pfc_debounce.sv ====
/*
  Persistence filter for the over-temperature fault condition.
  Assumes the condition comes from logic on mclk; needs no synchroniser.
*/
`timescale 1ns/10ps
`include "pfc_params.svh"

module pfc_debounce
  import pfc_pkg::*;
#(
  parameter int unsigned CYCLES = `PFC_DEBOUNCE_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cond,
  output logic fault_r
);

  localparam logic [`PFC_DEB_W-1:0] LAST = `PFC_DEB_W'(CYCLES - 1);

  pfc_deb_t st_r;
  pfc_deb_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    case (st_r.st)
      PFC_DEB_IDLE: begin
        st_nxt.cnt = '0;
        if (cond) begin
          st_nxt.st = PFC_DEB_CNT;
        end
      end
      PFC_DEB_CNT: begin
        // A single clear sample restarts the whole interval
        if (!cond) begin
          st_nxt.st = PFC_DEB_IDLE;
          st_nxt.cnt = '0;
        end else if (st_r.cnt >= LAST - `PFC_DEB_W'(1) || LAST == '0) begin
          st_nxt.st = PFC_DEB_FLT;
          st_nxt.fault = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt + `PFC_DEB_W'(1);
        end
      end
      PFC_DEB_FLT: begin
        if (!cond) begin
          st_nxt.st = PFC_DEB_IDLE;
          st_nxt.fault = 1'b0;
        end
      end
      default: begin
        st_nxt.st = PFC_DEB_IDLE;
        st_nxt.cnt = '0;
        st_nxt.fault = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_r <= '{st: PFC_DEB_IDLE, cnt: '0, fault: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fault_r = st_r.fault;

endmodule

// ==== rtl/pfc_cfg.sv ====
/*
  PWM output control, minimum on/off limits, temperature ADC trim and
  over-temperature fault threshold of a digital PFC controller.
  Assumes a management-bus slave on mclk that presents byte writes and
  reads as one-cycle strobes, an unlock level from the lock logic, and
  ADC samples on mclk with a one-cycle valid strobe.
*/
`timescale 1ns/10ps
`include "pfc_params.svh"

module pfc_cfg
  import pfc_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = `PFC_DEBOUNCE_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic trim_unlock,
  input wire logic [`PFC_ADC_W-1:0] adc_data,
  input wire logic adc_valid,
  output logic [7:0] reg_rdata_r,
  output logic reg_rvalid_r,
  output logic reg_wr_reject_r,
  output logic bridgeless_r,
  output logic fine_res_r,
  output logic [`PFC_STEP_W-1:0] edge_step_ns_r,
  output logic pwm_out_en_r,
  output logic second_pulse_output_en_r,
  output logic [`PFC_LIM_CYC_W-1:0] min_on_cyc_r,
  output logic [`PFC_LIM_CYC_W-1:0] min_off_cyc_r,
  output logic commit_r,
  output logic [`PFC_ADC_W-1:0] temp_trimmed_r,
  output logic temp_trimmed_valid_r,
  output logic ot_fault_r
);

  localparam logic [7:0] CTRL_WMASK = `PFC_DUAL_PHASE ? ~`PFC_CTRL_RSVD_MASK
                                                      : ~(`PFC_CTRL_RSVD_MASK | `PFC_CTRL_MODE_MASK);
  localparam int W = 16;

  pfc_cfg_st_t st_r;
  pfc_cfg_st_t st_nxt;

  // Minimum on time: code times 80 ns, in whole clock cycles
  function automatic logic [`PFC_LIM_CYC_W-1:0] min_on_cycles(input logic [3:0] code);
    int unsigned ns;
    ns = 32'(code) * `PFC_MIN_ON_STEP_NS;
    return `PFC_LIM_CYC_W'((ns + `PFC_CLK_NS - 1) / `PFC_CLK_NS);
  endfunction

  // Minimum off time: code 0 is a 40 ns floor, every other code is code times 80 ns
  function automatic logic [`PFC_LIM_CYC_W-1:0] min_off_cycles(input logic [3:0] code);
    int unsigned ns;
    if (code == 4'h0) begin
      ns = `PFC_MIN_OFF_FLOOR_NS;
    end else begin
      ns = 32'(code) * `PFC_MIN_OFF_STEP_NS;
    end
    return `PFC_LIM_CYC_W'((ns + `PFC_CLK_NS - 1) / `PFC_CLK_NS);
  endfunction

  function automatic logic is_trim_addr(input logic [15:0] a);
    return (a == `PFC_REG_OFS_HI) || (a == `PFC_REG_OFS_LO) || (a == `PFC_REG_GAIN);
  endfunction

  function automatic logic signed [W-1:0] offset_mag(input logic [7:0] hi, input logic [7:0] lo);
    return $signed({7'h00, hi[`PFC_OFS_MSB_BIT], lo});
  endfunction

  // Gain step is 2^-10 of the offset-corrected value per code
  function automatic logic signed [W-1:0] gain_corr(input logic signed [W-1:0] v, input logic [6:0] mag);
    logic signed [2*W-1:0] prod;
    prod = (2*W)'(v) * $signed((2*W)'(mag));
    return W'(prod >>> `PFC_GAIN_SHIFT);
  endfunction

  // Trim can push the reading out of range; saturate rather than wrap
  function automatic logic [`PFC_ADC_W-1:0] clamp_adc(input logic signed [W-1:0] v);
    if (v < 0) begin
      return '0;
    end else if (v > $signed(W'({`PFC_ADC_W{1'b1}}))) begin
      return {`PFC_ADC_W{1'b1}};
    end
    return v[`PFC_ADC_W-1:0];
  endfunction

  function automatic logic [`PFC_STEP_W-1:0] edge_step(input logic fine);
    if (fine) begin
      return `PFC_STEP_W'(`PFC_FINE_STEP_NS);
    end
    return `PFC_STEP_W'(`PFC_COARSE_STEP_NS);
  endfunction

  // Zero on top keeps the threshold unsigned against the nine top reading bits
  function automatic logic below_threshold(input logic [`PFC_ADC_W-1:0] r, input logic [7:0] thr);
    logic [`PFC_CMP_W-1:0] thr9;
    logic [`PFC_CMP_W-1:0] rd9;
    thr9 = {1'b0, thr};
    rd9 = r[`PFC_ADC_W-1 -: `PFC_CMP_W];
    return rd9 < thr9;
  endfunction

  // Offset first, then gain on the offset-corrected value; result clamps to the ADC range
  function automatic logic [`PFC_ADC_W-1:0] apply_trim(
    input logic [`PFC_ADC_W-1:0] raw,
    input logic [7:0] ofs_hi,
    input logic [7:0] ofs_lo,
    input logic [7:0] gain
  );
    logic signed [W-1:0] v;
    logic signed [W-1:0] mag;
    logic signed [W-1:0] corr;
    v = $signed(W'(raw));
    mag = offset_mag(ofs_hi, ofs_lo);
    if (ofs_hi[`PFC_OFS_SIGN_BIT]) begin
      v = v - mag;
    end else begin
      v = v + mag;
    end
    corr = gain_corr(v, gain[6:0]);
    if (gain[`PFC_GAIN_SIGN_BIT]) begin
      v = v - corr;
    end else begin
      v = v + corr;
    end
    return clamp_adc(v);
  endfunction

  function automatic logic [7:0] read_mux(input logic [15:0] a, input pfc_cfg_st_t s);
    case (a)
      `PFC_REG_CTRL: begin
        return s.ctrl_stg & CTRL_WMASK;
      end
      `PFC_REG_LIMIT: begin
        return s.limit_stg;
      end
      `PFC_REG_OFS_HI: begin
        return s.ofs_hi;
      end
      `PFC_REG_OFS_LO: begin
        return s.ofs_lo;
      end
      `PFC_REG_GAIN: begin
        return s.gain;
      end
      `PFC_REG_OT_THR: begin
        return s.ot_thr;
      end
      default: begin
        return 8'h00;
      end
    endcase
  endfunction

  always_comb begin
    logic [7:0] ctrl_new;
    logic go_edge;
    ctrl_new = st_r.ctrl_stg;
    go_edge = 1'b0;
    st_nxt = st_r;
    st_nxt.commit = 1'b0;
    st_nxt.rvalid = 1'b0;
    st_nxt.wr_reject = 1'b0;
    st_nxt.trim_valid = 1'b0;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `PFC_REG_CTRL: begin
          ctrl_new = reg_wdata & CTRL_WMASK;
          // Go must be written low again before another write can commit
          go_edge = ctrl_new[`PFC_CTRL_GO_BIT] && !st_r.ctrl_stg[`PFC_CTRL_GO_BIT];
          st_nxt.ctrl_stg = ctrl_new;
        end
        `PFC_REG_LIMIT: begin
          st_nxt.limit_stg = reg_wdata;
        end
        `PFC_REG_OFS_HI: begin
          if (trim_unlock) begin
            st_nxt.ofs_hi = reg_wdata;
          end
        end
        `PFC_REG_OFS_LO: begin
          if (trim_unlock) begin
            st_nxt.ofs_lo = reg_wdata;
          end
        end
        `PFC_REG_GAIN: begin
          if (trim_unlock) begin
            st_nxt.gain = reg_wdata;
          end
        end
        `PFC_REG_OT_THR: begin
          // Out-of-span codes are stored as written; keeping to 0x03..0xfa is the host's job
          st_nxt.ot_thr = reg_wdata;
        end
        default: begin
          st_nxt.rvalid = 1'b0;
        end
      endcase
      if (is_trim_addr(reg_addr) && !trim_unlock) begin
        st_nxt.wr_reject = 1'b1;
      end
    end

    // Commit: the staged byte being written carries the new control settings
    if (go_edge) begin
      st_nxt.commit = 1'b1;
      st_nxt.act_bridgeless = `PFC_DUAL_PHASE & ctrl_new[`PFC_CTRL_MODE_BIT];
      st_nxt.act_fine = ctrl_new[`PFC_CTRL_RES_BIT];
      st_nxt.step_ns = edge_step(ctrl_new[`PFC_CTRL_RES_BIT]);
      st_nxt.act_en1 = !ctrl_new[`PFC_CTRL_DIS1_BIT];
      st_nxt.act_en2 = !ctrl_new[`PFC_CTRL_DIS2_BIT];
      // Limit byte must be staged at least one cycle before the go write
      st_nxt.min_on_cyc = min_on_cycles(st_r.limit_stg[7:4]);
      st_nxt.min_off_cyc = min_off_cycles(st_r.limit_stg[3:0]);
    end

    // Register reads answer one cycle later; a read in a write cycle sees the old value
    if (reg_rd) begin
      st_nxt.rdata = read_mux(reg_addr, st_r);
      st_nxt.rvalid = 1'b1;
    end

    // Trim path and threshold compare, one stage each
    if (adc_valid) begin
      st_nxt.trimmed = apply_trim(adc_data, st_r.ofs_hi, st_r.ofs_lo, st_r.gain);
      st_nxt.trim_valid = 1'b1;
    end
    st_nxt.below_thr = below_threshold(st_r.trimmed, st_r.ot_thr);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_r.ctrl_stg <= `PFC_CTRL_RST;
      st_r.limit_stg <= `PFC_LIMIT_RST;
      st_r.ofs_hi <= `PFC_TRIM_RST;
      st_r.ofs_lo <= `PFC_TRIM_RST;
      st_r.gain <= `PFC_TRIM_RST;
      st_r.ot_thr <= `PFC_OT_THR_RST;
      st_r.act_bridgeless <= 1'b0;
      st_r.act_fine <= 1'b0;
      st_r.act_en1 <= 1'b1;
      st_r.act_en2 <= 1'b1;
      st_r.step_ns <= `PFC_STEP_W'(`PFC_COARSE_STEP_NS);
      st_r.min_on_cyc <= '0;
      st_r.min_off_cyc <= `PFC_LIM_CYC_W'(`PFC_MIN_OFF_FLOOR_NS / `PFC_CLK_NS);
      st_r.commit <= 1'b0;
      st_r.rdata <= 8'h00;
      st_r.rvalid <= 1'b0;
      st_r.wr_reject <= 1'b0;
      // Full-scale reading sits above any threshold, so no fault is seen before the first sample
      st_r.trimmed <= {`PFC_ADC_W{1'b1}};
      st_r.trim_valid <= 1'b0;
      st_r.below_thr <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  pfc_debounce #(
    .CYCLES(DEBOUNCE_CYCLES)
  ) u_ot_deb (
    .mclk(mclk),
    .rstn(rstn),
    .cond(st_r.below_thr),
    .fault_r(ot_fault_r)
  );

  assign reg_rdata_r = st_r.rdata;
  assign reg_rvalid_r = st_r.rvalid;
  assign reg_wr_reject_r = st_r.wr_reject;
  assign bridgeless_r = st_r.act_bridgeless;
  assign fine_res_r = st_r.act_fine;
  assign edge_step_ns_r = st_r.step_ns;
  assign pwm_out_en_r = st_r.act_en1;
  assign second_pulse_output_en_r = st_r.act_en2;
  assign min_on_cyc_r = st_r.min_on_cyc;
  assign min_off_cyc_r = st_r.min_off_cyc;
  assign commit_r = st_r.commit;
  assign temp_trimmed_r = st_r.trimmed;
  assign temp_trimmed_valid_r = st_r.trim_valid;

endmodule

// ==== tb/pfc_cfg_checker.sv ====
/* Port assertions for pfc_cfg.
   Assumes one clock mclk and synchronous active-low rstn. */
`timescale 1ns/10ps
module pfc_cfg_checker #(
  parameter int unsigned DEBOUNCE_CYCLES = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic trim_unlock,
  input wire logic [7:0] reg_rdata_r,
  input wire logic reg_rvalid_r,
  input wire logic reg_wr_reject_r,
  input wire logic bridgeless_r,
  input wire logic fine_res_r,
  input wire logic [5:0] edge_step_ns_r,
  input wire logic pwm_out_en_r,
  input wire logic second_pulse_output_en_r,
  input wire logic [8:0] min_on_cyc_r,
  input wire logic [8:0] min_off_cyc_r,
  input wire logic commit_r,
  input wire logic ot_fault_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_mode; commit_r |-> bridgeless_r == $past(reg_wdata[4]); endproperty
  a_mode: assert property (p_mode) else $error("mode differs from committed byte");
  property p_res; commit_r |-> fine_res_r == $past(reg_wdata[3]) && edge_step_ns_r == (fine_res_r ? 6'h05 : 6'h28);
  endproperty
  a_res: assert property (p_res) else $error("edge step differs from committed byte");
  property p_en1; commit_r |-> pwm_out_en_r != $past(reg_wdata[2]); endproperty
  a_en1: assert property (p_en1) else $error("primary enable wrong");
  property p_en2; commit_r |-> second_pulse_output_en_r != $past(reg_wdata[1]); endproperty
  a_en2: assert property (p_en2) else $error("second enable wrong");
  property p_go; commit_r |-> $past(reg_wr && reg_addr == 16'hfe14 && reg_wdata[0]); endproperty
  a_go: assert property (p_go) else $error("commit without a go write");
  // Active settings may only move at a commit
  property p_stg;
    !commit_r |-> $stable({bridgeless_r, fine_res_r, pwm_out_en_r, second_pulse_output_en_r, min_on_cyc_r,
      min_off_cyc_r});
  endproperty
  a_stg: assert property (p_stg) else $error("active settings moved without commit");
  property p_rej; reg_wr && !trim_unlock && reg_addr inside {16'hfe16, 16'hfe17, 16'hfe18} |=> reg_wr_reject_r;
  endproperty
  a_rej: assert property (p_rej) else $error("locked trim write not refused");
  property p_rd; reg_rd |=> reg_rvalid_r; endproperty
  a_rd: assert property (p_rd) else $error("read answer missing");
  property p_rsv; reg_rvalid_r && $past(reg_addr == 16'hfe14) |-> reg_rdata_r[7:5] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved control bits not zero");
  c_commit: cover property (commit_r);
  c_rej: cover property (reg_wr_reject_r);
  c_flt: cover property ($rose(ot_fault_r));
endmodule
bind pfc_cfg pfc_cfg_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) i_chk (.mclk, .rstn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .trim_unlock, .reg_rdata_r, .reg_rvalid_r, .reg_wr_reject_r, .bridgeless_r, .fine_res_r,
  .edge_step_ns_r, .pwm_out_en_r, .second_pulse_output_en_r, .min_on_cyc_r, .min_off_cyc_r, .commit_r, .ot_fault_r);

// ==== tb/pfc_host_model.sv ====
/* Host controller model on the register port.
   Assumes strobes are sampled on rising mclk; drives at falling edges. */
`timescale 1ns/10ps
module pfc_host_model (
  input wire logic mclk,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic trim_unlock
);
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    trim_unlock = 1'b0;
  end
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    // Host keeps fault thresholds inside the allowed span
    if (w && a == 16'hfe19 && (d < 8'h03 || d > 8'hfa)) d = 8'h03;
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Released lines show inverted leftovers, so a late sample cannot match by luck
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic lock(input logic u);
    @(negedge mclk);
    trim_unlock = u;
  endtask
endmodule

// ==== tb/pfc_cfg_tb_top.sv ====
/* Self-checking bench for pfc_cfg with a host model on the register port.
   Assumes a short debounce parameter of 8 cycles. */
`timescale 1ns/10ps
module pfc_cfg_tb_top;
  logic mclk, rstn, reg_wr, reg_rd, trim_unlock, adc_valid, reg_rvalid_r, reg_wr_reject_r, bridgeless_r, fine_res_r;
  logic pwm_out_en_r, second_pulse_output_en_r, commit_r, temp_trimmed_valid_r, ot_fault_r;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_r, c, l, h, lo, g;
  logic [11:0] adc_data, temp_trimmed_r;
  logic [5:0] edge_step_ns_r;
  logic [8:0] min_on_cyc_r, min_off_cyc_r;
  logic [27:0] act;
  logic [31:0] rq[$], cq[$], tq[$];
  logic [7:0] rst_v[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
  int failures, checked, seed, rejs, cyc, raw;
  assign act = {bridgeless_r, fine_res_r, edge_step_ns_r, pwm_out_en_r, second_pulse_output_en_r, min_on_cyc_r,
    min_off_cyc_r};
  pfc_host_model i_host (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .trim_unlock);
  pfc_cfg #(.DEBOUNCE_CYCLES(8)) i_dut (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .trim_unlock,
    .adc_data, .adc_valid, .reg_rdata_r, .reg_rvalid_r, .reg_wr_reject_r, .bridgeless_r, .fine_res_r,
    .edge_step_ns_r, .pwm_out_en_r, .second_pulse_output_en_r, .min_on_cyc_r, .min_off_cyc_r, .commit_r,
    .temp_trimmed_r, .temp_trimmed_valid_r, .ot_fault_r);
  always #2 mclk = ~mclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    rq.push_back(e);
    i_host.acc(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_host.acc(1'b1, a, d);
  endtask
  task automatic sample(input logic [11:0] r, input logic [11:0] e);
    tq.push_back(e);
    @(negedge mclk);
    adc_data = r;
    adc_valid = 1'b1;
    @(negedge mclk);
    adc_valid = 1'b0;
  endtask
  function automatic logic [27:0] cexp(input logic [7:0] cc, input logic [7:0] ll);
    return {cc[4], cc[3], cc[3] ? 6'h05 : 6'h28, !cc[2], !cc[1], 9'(ll[7:4] * 20),
      ll[3:0] == 4'h0 ? 9'h00a : 9'(ll[3:0] * 20)};
  endfunction
  function automatic logic [11:0] texp(input int r, input logic [7:0] hh, input logic [7:0] ll, input logic [7:0] gg);
    int v;
    int k;
    v = hh[1] ? r - int'({hh[0], ll}) : r + int'({hh[0], ll});
    k = (v * int'(gg[6:0])) >>> 10;
    v = gg[7] ? v - k : v + k;
    return v < 0 ? 12'h000 : v > 4095 ? 12'hfff : 12'(v);
  endfunction
  // Results are matched against the oldest note as they appear
  always @(negedge mclk) begin
    if (rstn && reg_rvalid_r) chk("read data", rq.size() ? rq.pop_front() : 'x, reg_rdata_r);
    if (rstn && commit_r) chk("committed outputs", cq.size() ? cq.pop_front() : 'x, act);
    if (rstn && temp_trimmed_valid_r) chk("trimmed", tq.size() ? tq.pop_front() : 'x, temp_trimmed_r);
    if (rstn && reg_wr_reject_r) rejs++;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    seed = 32'hbd86;
    {mclk, rstn, adc_valid, failures, checked, rejs, cyc} = '0;
    adc_data = 12'h000;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    chk("reset outputs", cexp(8'h00, 8'h00), act);
    foreach (rst_v[i]) rd(16'hfe14 + 16'(i), rst_v[i]);
    rd(16'hfe1a, 8'h00);
    for (int i = 0; i < 6; i++) begin
      l = i == 0 ? 8'hf0 : i == 1 ? 8'h0f : 8'($random(seed));
      c = i == 0 ? 8'h1f : i == 1 ? 8'h01 : 8'($random(seed)) | 8'h01;
      wr(16'hfe14, 8'h00);
      wr(16'hfe15, l);
      cq.push_back(cexp(c, l));
      wr(16'hfe14, c);
      rd(16'hfe14, c & 8'h1f);
      wr(16'hfe15, ~l);
      wr(16'hfe14, c ^ 8'h1e);
      chk("held outputs", cexp(c, l), act);
    end
    wr(16'hfe16, 8'h02);
    wr(16'hfe17, 8'h10);
    wr(16'hfe18, 8'hc0);
    rd(16'hfe16, 8'h00);
    i_host.lock(1'b1);
    for (int i = 0; i < 8; i++) begin
      h = 8'($random(seed)) & 8'h03;
      {lo, g} = 16'($random(seed));
      raw = $random(seed) & 32'hfff;
      wr(16'hfe16, h);
      wr(16'hfe17, lo);
      wr(16'hfe18, g);
      rd(16'hfe18, g);
      sample(12'(raw), texp(raw, h, lo, g));
    end
    wr(16'hfe16, 8'h00);
    wr(16'hfe17, 8'h00);
    wr(16'hfe18, 8'h00);
    wr(16'hfe19, 8'hfa);
    sample(12'hf80, 12'hf80);
    repeat (20) @(negedge mclk);
    chk("fault above", 0, ot_fault_r);
    sample(12'h7c0, 12'h7c0);
    repeat (8) @(negedge mclk);
    chk("fault early", 0, ot_fault_r);
    @(negedge mclk);
    chk("fault set", 1, ot_fault_r);
    sample(12'hf80, 12'hf80);
    @(negedge mclk);
    chk("fault hold", 1, ot_fault_r);
    @(negedge mclk);
    chk("fault clear", 0, ot_fault_r);
    sample(12'h7c0, 12'h7c0);
    sample(12'hf80, 12'hf80);
    repeat (20) @(negedge mclk);
    chk("short dip", 0, ot_fault_r);
    chk("rejects", 3, rejs);
    chk("pending", 0, rq.size() + cq.size() + tq.size());
    stop_test();
  end
endmodule
